// File: shared/fast_ir_line_pkg.sv
// Purpose: Constants for the fast infrared line control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Register indexes are kept as printed; byte address is four times the index
package fast_ir_line_pkg;

  // ----------------------------------------------------------------
  // Register indexes and byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] LINE_CODING_IDX = 32'h0f00085c;
  localparam logic [31:0] FAST_IR_IDX = 32'h0f00085e;
  localparam logic [31:0] BLOCK_ENABLE_IDX = 32'h0f000870;
  localparam logic [31:0] LINE_STATUS_IDX = 32'h0f000872;
  localparam logic [31:0] LINE_CODING_ADDR = 32'h3c002170;
  localparam logic [31:0] FAST_IR_ADDR = 32'h3c002178;
  localparam logic [31:0] BLOCK_ENABLE_ADDR = 32'h3c0021c0;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h3c0021c8;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] LINE_CODING_RESET = 16'h0000;
  localparam logic [15:0] FAST_IR_RESET = 16'h0085;
  localparam logic [15:0] LINE_CODING_WMASK = 16'h00f7;
  localparam logic [15:0] FAST_IR_WMASK = 16'h00e7;

  // ----------------------------------------------------------------
  // Line coding control fields
  // ----------------------------------------------------------------
  localparam int TX_ENABLE_BIT = 7;
  localparam int RX_ENABLE_BIT = 6;
  localparam int PPM_MOD_DISABLE_BIT = 5;
  localparam int BIT_CORRECT_DISABLE_BIT = 4;
  localparam int OMIT_CHECKSUM_BIT = 2;
  localparam int CHECKSUM_INVERT_BIT = 1;
  localparam int LINE_DATA_INVERT_BIT = 0;

  // ----------------------------------------------------------------
  // Fast infrared control fields
  // ----------------------------------------------------------------
  localparam int PREAMBLE_COUNT_LSB = 5;
  localparam int PULSE_WINDOW_LSB = 3;
  localparam int PULSE_WIDTH_LSB = 0;
  localparam logic [3:0] SINGLE_WIDTH_OFFSET = 4'h1;
  localparam logic [3:0] DOUBLE_WIDTH_OFFSET = 4'h7;
  localparam logic [3:0] WINDOW_LOW_BASE = 4'h7;
  localparam logic [3:0] WINDOW_HIGH_BASE = 4'h8;
  localparam logic [3:0] WIDTH_COUNT_MAX = 4'hf;
  localparam logic [2:0] PULSE_WIDTH_MAX_CODE = 3'h5;

  // ----------------------------------------------------------------
  // Preamble codes and symbol counts
  // ----------------------------------------------------------------
  localparam logic [2:0] PREAMBLE_CODE_16 = 3'h4;
  localparam logic [2:0] PREAMBLE_CODE_4 = 3'h3;
  localparam logic [2:0] PREAMBLE_CODE_2 = 3'h2;
  localparam logic [2:0] PREAMBLE_CODE_1 = 3'h1;
  localparam logic [4:0] PREAMBLE_SYMBOLS_16 = 5'h10;
  localparam logic [4:0] PREAMBLE_SYMBOLS_4 = 5'h04;
  localparam logic [4:0] PREAMBLE_SYMBOLS_2 = 5'h02;
  localparam logic [4:0] PREAMBLE_SYMBOLS_1 = 5'h01;

  // ----------------------------------------------------------------
  // Receive pulse classifier states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_HIGH = 2'b10
  } rx_state_t;

endpackage

// File: logic/fast_infrared_line_control.sv
// Purpose: Line coding and pulse shaping control for a fast infrared controller
// Assumes: 20 MHz i_clk; i_ref_tick marks one reference clock cycle in this domain
// Notes: Registers reached over APB, zero wait states
`timescale 1ns/100ps

module fast_infrared_line_control (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Reference clock tick
  input wire logic i_ref_tick,
  // Transmit sequencer
  input wire logic i_tx_frame_length_reg_write,
  output logic o_tx_seq_start,
  output logic o_ppm_mod_enable,
  output logic o_append_checksum,
  output logic [4:0] o_preamble_count,
  input wire logic [31:0] i_crc_word,
  output logic [31:0] o_tx_crc_word,
  // Transmit pulse shaper
  input wire logic i_tx_pulse_start,
  input wire logic i_tx_pulse_double,
  output logic o_tx_line,
  // Receive path
  input wire logic i_rx_line,
  output logic o_rx_sample_enable,
  output logic o_bit_correct_enable,
  output logic o_rx_single,
  output logic o_rx_double,
  // Main block control
  output logic o_main_rst_b,
  output logic o_main_clk_en
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] line_coding_reg;
  logic [15:0] fast_ir_reg;
  logic block_enable_reg;
  logic [31:0] prdata_reg;
  logic rx_sync1_reg;
  logic rx_sync2_reg;
  fast_ir_line_pkg::rx_state_t rx_state_reg;
  fast_ir_line_pkg::rx_state_t rx_state_next;
  logic [3:0] rx_width_reg;
  logic [3:0] rx_width_next;
  logic rx_single_reg;
  logic rx_double_reg;
  logic [3:0] tx_count_reg;
  logic [3:0] tx_count_next;
  logic tx_line_reg;
  logic [31:0] tx_crc_reg;
  logic tx_start_reg;
  logic main_rst_b_reg;
  logic main_clk_en_reg;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire logic tx_enable = line_coding_reg[fast_ir_line_pkg::TX_ENABLE_BIT];
  wire logic rx_enable = line_coding_reg[fast_ir_line_pkg::RX_ENABLE_BIT];
  wire logic ppm_mod_disable = line_coding_reg[fast_ir_line_pkg::PPM_MOD_DISABLE_BIT];
  wire logic bit_correct_disable = line_coding_reg[fast_ir_line_pkg::BIT_CORRECT_DISABLE_BIT];
  wire logic omit_checksum = line_coding_reg[fast_ir_line_pkg::OMIT_CHECKSUM_BIT];
  wire logic checksum_invert = line_coding_reg[fast_ir_line_pkg::CHECKSUM_INVERT_BIT];
  wire logic line_data_invert = line_coding_reg[fast_ir_line_pkg::LINE_DATA_INVERT_BIT];
  wire logic [2:0] preamble_code = fast_ir_reg[fast_ir_line_pkg::PREAMBLE_COUNT_LSB +: 3];
  wire logic [1:0] pulse_window = fast_ir_reg[fast_ir_line_pkg::PULSE_WINDOW_LSB +: 2];
  wire logic [2:0] pulse_width = fast_ir_reg[fast_ir_line_pkg::PULSE_WIDTH_LSB +: 3];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic hit_line_coding = (i_paddr == fast_ir_line_pkg::LINE_CODING_ADDR);
  wire logic hit_fast_ir = (i_paddr == fast_ir_line_pkg::FAST_IR_ADDR);
  wire logic hit_block_enable = (i_paddr == fast_ir_line_pkg::BLOCK_ENABLE_ADDR);
  wire logic hit_status = (i_paddr == fast_ir_line_pkg::LINE_STATUS_ADDR);
  wire logic hit_any = hit_line_coding | hit_fast_ir | hit_block_enable | hit_status;
  wire logic setup_phase = i_psel & ~i_penable;
  wire logic access_phase = i_psel & i_penable;
  wire logic wr_access = access_phase & i_pwrite & hit_any;

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  wire logic tx_busy = (tx_count_reg != 4'h0);
  wire logic rx_in_pulse = (rx_state_reg == fast_ir_line_pkg::RX_HIGH);
  wire logic [31:0] status_word = {29'h0, rx_double_reg, rx_in_pulse, tx_busy};
  logic [31:0] read_word;

  always_comb begin
    if (hit_line_coding) begin
      read_word = {16'h0, line_coding_reg};
    end else if (hit_fast_ir) begin
      read_word = {16'h0, fast_ir_reg};
    end else if (hit_block_enable) begin
      read_word = {31'h0, block_enable_reg};
    end else if (hit_status) begin
      read_word = status_word;
    end else begin
      read_word = 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  assign o_pready = 1'b1;
  assign o_pslverr = access_phase & ~hit_any;
  assign o_prdata = prdata_reg;

  // ----------------------------------------------------------------
  // Register writes and read capture
  // ----------------------------------------------------------------
  wire logic [15:0] line_coding_next = i_pwdata[15:0] & fast_ir_line_pkg::LINE_CODING_WMASK;
  // Window field is read-only; its bits keep their value across writes
  wire logic [15:0] fast_ir_next = (i_pwdata[15:0] & fast_ir_line_pkg::FAST_IR_WMASK)
    | (fast_ir_reg & ~fast_ir_line_pkg::FAST_IR_WMASK);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_coding_reg <= fast_ir_line_pkg::LINE_CODING_RESET;
      fast_ir_reg <= fast_ir_line_pkg::FAST_IR_RESET;
      block_enable_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      if (wr_access && hit_line_coding) begin
        line_coding_reg <= line_coding_next;
      end
      if (wr_access && hit_fast_ir) begin
        fast_ir_reg <= fast_ir_next;
      end
      if (wr_access && hit_block_enable) begin
        block_enable_reg <= i_pwdata[0];
      end
      if (setup_phase && !i_pwrite) begin
        prdata_reg <= read_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Main block control
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      main_rst_b_reg <= 1'b0;
      main_clk_en_reg <= 1'b0;
    end else begin
      main_rst_b_reg <= block_enable_reg;
      main_clk_en_reg <= block_enable_reg;
    end
  end

  // ----------------------------------------------------------------
  // Main block outputs
  // ----------------------------------------------------------------
  assign o_main_rst_b = main_rst_b_reg;
  assign o_main_clk_en = main_clk_en_reg;

  // ----------------------------------------------------------------
  // Transmit control
  // ----------------------------------------------------------------
  logic [4:0] preamble_symbols;

  always_comb begin
    case (preamble_code)
      fast_ir_line_pkg::PREAMBLE_CODE_16: preamble_symbols = fast_ir_line_pkg::PREAMBLE_SYMBOLS_16;
      fast_ir_line_pkg::PREAMBLE_CODE_4: preamble_symbols = fast_ir_line_pkg::PREAMBLE_SYMBOLS_4;
      fast_ir_line_pkg::PREAMBLE_CODE_2: preamble_symbols = fast_ir_line_pkg::PREAMBLE_SYMBOLS_2;
      fast_ir_line_pkg::PREAMBLE_CODE_1: preamble_symbols = fast_ir_line_pkg::PREAMBLE_SYMBOLS_1;
      default: preamble_symbols = 5'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Transmit start and checksum
  // ----------------------------------------------------------------
  wire logic tx_start_next = i_tx_frame_length_reg_write & tx_enable & block_enable_reg;
  wire logic [31:0] tx_crc_next = checksum_invert ? ~i_crc_word : i_crc_word;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_start_reg <= 1'b0;
      tx_crc_reg <= 32'h0;
    end else begin
      tx_start_reg <= tx_start_next;
      tx_crc_reg <= tx_crc_next;
    end
  end

  // ----------------------------------------------------------------
  // Transmit outputs
  // ----------------------------------------------------------------
  assign o_tx_seq_start = tx_start_reg;
  assign o_tx_crc_word = tx_crc_reg;
  assign o_ppm_mod_enable = ~ppm_mod_disable;
  assign o_append_checksum = ~omit_checksum;
  assign o_preamble_count = preamble_symbols;

  // ----------------------------------------------------------------
  // Transmit pulse shaper
  // ----------------------------------------------------------------
  // Widths saturate at the largest legal code so a prohibited code cannot overrun
  wire logic [2:0] width_code = (pulse_width > fast_ir_line_pkg::PULSE_WIDTH_MAX_CODE)
    ? fast_ir_line_pkg::PULSE_WIDTH_MAX_CODE : pulse_width;
  wire logic [3:0] single_width = {1'b0, width_code} + fast_ir_line_pkg::SINGLE_WIDTH_OFFSET;
  wire logic [3:0] double_width = {1'b0, width_code} + fast_ir_line_pkg::DOUBLE_WIDTH_OFFSET;

  // ----------------------------------------------------------------
  // Transmit pulse counter
  // ----------------------------------------------------------------
  always_comb begin
    tx_count_next = tx_count_reg;
    if (i_tx_pulse_start && !tx_busy && block_enable_reg) begin
      tx_count_next = i_tx_pulse_double ? double_width : single_width;
    end else if (tx_busy && i_ref_tick) begin
      tx_count_next = tx_count_reg - 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_count_reg <= 4'h0;
      tx_line_reg <= 1'b0;
    end else begin
      tx_count_reg <= tx_count_next;
      tx_line_reg <= (tx_count_next != 4'h0) ^ line_data_invert;
    end
  end

  assign o_tx_line = tx_line_reg;

  // ----------------------------------------------------------------
  // Receive line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_sync1_reg <= 1'b0;
      rx_sync2_reg <= 1'b0;
    end else begin
      rx_sync1_reg <= i_rx_line;
      rx_sync2_reg <= rx_sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Receive enable mask
  // ----------------------------------------------------------------
  wire logic rx_open = rx_enable & block_enable_reg;
  wire logic rx_level = rx_open & (rx_sync2_reg ^ line_data_invert);

  assign o_rx_sample_enable = rx_open;
  assign o_bit_correct_enable = ~bit_correct_disable;

  // ----------------------------------------------------------------
  // Receive pulse classifier
  // ----------------------------------------------------------------
  wire logic [3:0] window_low = fast_ir_line_pkg::WINDOW_LOW_BASE + {2'b00, pulse_window};
  wire logic [3:0] window_high = fast_ir_line_pkg::WINDOW_HIGH_BASE + {2'b00, pulse_window};
  wire logic width_in_window = (rx_width_reg >= window_low) && (rx_width_reg <= window_high);
  wire logic rx_pulse_end = rx_in_pulse & ~rx_level;

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_width_next = rx_width_reg;
    case (rx_state_reg)
      fast_ir_line_pkg::RX_IDLE: begin
        rx_width_next = 4'h0;
        if (rx_level) begin
          rx_state_next = fast_ir_line_pkg::RX_HIGH;
          if (i_ref_tick) begin
            rx_width_next = 4'h1;
          end
        end
      end
      fast_ir_line_pkg::RX_HIGH: begin
        if (!rx_level) begin
          rx_state_next = fast_ir_line_pkg::RX_IDLE;
        end else if (i_ref_tick && rx_width_reg != fast_ir_line_pkg::WIDTH_COUNT_MAX) begin
          rx_width_next = rx_width_reg + 4'h1;
        end
      end
      default: begin
        rx_state_next = fast_ir_line_pkg::RX_IDLE;
        rx_width_next = 4'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Receive state update
  // ----------------------------------------------------------------
  wire logic rx_single_next = rx_pulse_end & width_in_window;
  wire logic rx_double_next = rx_pulse_end & ~width_in_window;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_state_reg <= fast_ir_line_pkg::RX_IDLE;
      rx_width_reg <= 4'h0;
      rx_single_reg <= 1'b0;
      rx_double_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_width_reg <= rx_width_next;
      rx_single_reg <= rx_single_next;
      rx_double_reg <= rx_double_next;
    end
  end

  // ----------------------------------------------------------------
  // Receive outputs
  // ----------------------------------------------------------------
  assign o_rx_single = rx_single_reg;
  assign o_rx_double = rx_double_reg;

endmodule

// File: verif/fast_infrared_line_control_sva.sv
// Purpose: Port checks for the fast infrared line control block
// Assumes: One clock domain, asynchronous active low reset
// Notes: Attached by bind at the foot of this file
`timescale 1ns/100ps
module fast_infrared_line_control_sva (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Transmit side
  input wire logic i_tx_frame_length_reg_write,
  input wire logic o_tx_seq_start,
  input wire logic [4:0] o_preamble_count,
  input wire logic [31:0] i_crc_word,
  input wire logic [31:0] o_tx_crc_word,
  // Receive side and main block
  input wire logic o_rx_sample_enable,
  input wire logic o_rx_single,
  input wire logic o_rx_double,
  input wire logic o_main_rst_b,
  input wire logic o_main_clk_en
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence rx_masked_s;
    (!o_rx_sample_enable) [*8];
  endsequence
  sequence rx_result_s;
    o_rx_single || o_rx_double;
  endsequence
  a_pready_high: assert property (o_pready) else $error("pready low");
  a_slverr_access: assert property (o_pslverr |-> i_psel && i_penable) else $error("slverr outside access");
  a_start_cause: assert property (o_tx_seq_start |-> $past(i_tx_frame_length_reg_write)) else $error("start without write");
  a_start_enabled: assert property (o_tx_seq_start |-> o_main_clk_en) else $error("start while disabled");
  a_crc_select: assert property ($past(i_rst_b) |-> (o_tx_crc_word == $past(i_crc_word))
    || (o_tx_crc_word == ~$past(i_crc_word))) else $error("crc word wrong");
  a_rx_exclusive: assert property (!(o_rx_single && o_rx_double)) else $error("both results");
  a_rx_one_cycle: assert property (rx_result_s |=> !(o_rx_single || o_rx_double)) else $error("result too long");
  a_rx_masked: assert property (rx_masked_s |-> !(o_rx_single || o_rx_double)) else $error("result while masked");
  a_main_pair: assert property (o_main_rst_b == o_main_clk_en) else $error("main reset and clock differ");
  a_preamble_legal: assert property (o_preamble_count inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h10})
    else $error("bad preamble count");
endmodule
bind fast_infrared_line_control fast_infrared_line_control_sva chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_tx_frame_length_reg_write(i_tx_frame_length_reg_write), .o_tx_seq_start(o_tx_seq_start), .o_preamble_count(o_preamble_count),
  .i_crc_word(i_crc_word), .o_tx_crc_word(o_tx_crc_word), .o_rx_sample_enable(o_rx_sample_enable),
  .o_rx_single(o_rx_single), .o_rx_double(o_rx_double), .o_main_rst_b(o_main_rst_b),
  .o_main_clk_en(o_main_clk_en));

// File: verif/ir_front_end_model.sv
// Purpose: Optical front end model: measures sent pulses, sends received pulses
// Assumes: Widths counted in i_clk cycles, one reference tick per cycle
// Notes: Receive pin rests low when no light arrives
`timescale 1ns/100ps
module ir_front_end_model (
  // Clock
  input wire logic i_clk,
  // Optical transmit side
  input wire logic i_tx_line,
  output logic [3:0] o_tx_width,
  // Optical receive side
  input wire logic i_rx_go,
  input wire logic [3:0] i_rx_len,
  output logic o_rx_pin
);
  logic [3:0] tx_cnt_reg = 4'h0;
  logic [3:0] rx_cnt_reg = 4'h0;
  initial o_tx_width = 4'h0;
  always @(posedge i_clk) begin
    if (i_tx_line) begin
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
    end else if (tx_cnt_reg != 4'h0) begin
      o_tx_width <= tx_cnt_reg;
      tx_cnt_reg <= 4'h0;
    end
    if (i_rx_go) begin
      rx_cnt_reg <= i_rx_len;
    end else if (rx_cnt_reg != 4'h0) begin
      rx_cnt_reg <= rx_cnt_reg - 4'h1;
    end
  end
  assign o_rx_pin = (rx_cnt_reg != 4'h0);
endmodule

// File: verif/fast_infrared_line_control_tb.sv
// Purpose: Self-checking bench for the fast infrared line control block
// Assumes: Reference tick every cycle except for 10 cycles in one pulse width check, so widths are in i_clk cycles
// Notes: Random values from an xorshift generator with a fixed seed
`timescale 1ns/100ps
module fast_infrared_line_control_tb;
  logic clk, rst_b, psel, penable, pwrite, ref_tick, frame_len_wr, tps, tpd, rx_go, rx_pin, rerr, sg, db;
  logic [31:0] paddr, pwdata, prdata, crc, crc_out, rdat, seed;
  logic pready, pslverr, seq_start, ppm_en, app_crc, tx_line, samp_en, bc_en, single, double, mrst_b, mclk;
  logic [4:0] pre_cnt;
  logic [3:0] tx_width, rx_len;
  logic [7:0] v;
  int bad_count, check_count;
  fast_infrared_line_control uut (.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_ref_tick(ref_tick), .i_tx_frame_length_reg_write(frame_len_wr), .o_tx_seq_start(seq_start),
    .o_ppm_mod_enable(ppm_en), .o_append_checksum(app_crc), .o_preamble_count(pre_cnt), .i_crc_word(crc),
    .o_tx_crc_word(crc_out), .i_tx_pulse_start(tps), .i_tx_pulse_double(tpd), .o_tx_line(tx_line),
    .i_rx_line(rx_pin), .o_rx_sample_enable(samp_en), .o_bit_correct_enable(bc_en), .o_rx_single(single),
    .o_rx_double(double), .o_main_rst_b(mrst_b), .o_main_clk_en(mclk));
  ir_front_end_model fe (.i_clk(clk), .i_tx_line(tx_line), .o_tx_width(tx_width), .i_rx_go(rx_go),
    .i_rx_len(rx_len), .o_rx_pin(rx_pin));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [4:0] exp_pre(input int c);
    return (c == 4) ? 5'h10 : (c == 3) ? 5'h04 : (c == 2) ? 5'h02 : (c == 1) ? 5'h01 : 5'h00;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rx_pulse(input logic [3:0] n);
    @(posedge clk);
    rx_go <= 1'b1; rx_len <= n;
    @(posedge clk);
    rx_go <= 1'b0;
    sg = 1'b0; db = 1'b0;
    repeat (20) begin
      settle(1);
      sg = sg | single; db = db | double;
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #3000000;
    bad_count++;
    final_report;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, frame_len_wr, tps, tpd, rx_go} = 7'h00;
    paddr = 32'h0; pwdata = 32'h0; crc = 32'h0; rx_len = 4'h0; ref_tick = 1'b1; rst_b = 1'b0; seed = 32'd96236;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    settle(1);
    chk(pre_cnt, 5'h10);
    chk({ppm_en, bc_en, app_crc, samp_en, mrst_b}, 5'b11100);
    apb(1'b0, fast_ir_line_pkg::LINE_CODING_ADDR, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, fast_ir_line_pkg::FAST_IR_ADDR, 32'h0);
    chk(rdat, 32'h85);
    $display("test reset values done");
    apb(1'b1, fast_ir_line_pkg::LINE_CODING_ADDR, 32'hffffffff);
    apb(1'b0, fast_ir_line_pkg::LINE_CODING_ADDR, 32'h0);
    chk(rdat, 32'hf7);
    apb(1'b1, fast_ir_line_pkg::FAST_IR_ADDR, 32'hffffffff);
    apb(1'b0, fast_ir_line_pkg::FAST_IR_ADDR, 32'h0);
    chk(rdat, 32'he7);
    apb(1'b0, 32'h3c002100, 32'h0);
    chk(rdat, 32'h0);
    chk(rerr, 1'b1);
    $display("test reserved bits done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      v = seed[7:0] & 8'h37;
      apb(1'b1, fast_ir_line_pkg::LINE_CODING_ADDR, {24'h0, v});
      @(posedge clk);
      crc <= xs(seed);
      settle(2);
      chk({ppm_en, bc_en, app_crc}, {!v[5], !v[4], !v[2]});
      chk(crc_out, v[1] ? ~xs(seed) : xs(seed));
    end
    $display("test random line coding done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, fast_ir_line_pkg::FAST_IR_ADDR, c * 32 + 5);
      settle(1);
      chk(pre_cnt, exp_pre(c));
    end
    $display("test preamble codes done");
    apb(1'b1, fast_ir_line_pkg::BLOCK_ENABLE_ADDR, 32'h1);
    settle(1);
    chk({mrst_b, mclk}, 2'b11);
    apb(1'b0, fast_ir_line_pkg::BLOCK_ENABLE_ADDR, 32'h0);
    chk(rdat, 32'h1);
    for (int en = 0; en < 2; en++) begin
      apb(1'b1, fast_ir_line_pkg::LINE_CODING_ADDR, en * 128);
      @(posedge clk);
      frame_len_wr <= 1'b1;
      @(posedge clk);
      frame_len_wr <= 1'b0;
      #1;
      chk(seq_start, en);
    end
    $display("test transmit start done");
    apb(1'b1, fast_ir_line_pkg::LINE_CODING_ADDR, 32'h0);
    for (int c = 0; c < 12; c++) begin
      apb(1'b1, fast_ir_line_pkg::FAST_IR_ADDR, 32'h80 + c / 2);
      @(posedge clk);
      tps <= 1'b1; tpd <= c[0];
      @(posedge clk);
      tps <= 1'b0;
      settle(16);
      chk(tx_width, c / 2 + (c[0] ? 7 : 1));
    end
    @(posedge clk);
    ref_tick <= 1'b0;
    tps <= 1'b1;
    tpd <= 1'b0;
    @(posedge clk);
    tps <= 1'b0;
    repeat (9) @(posedge clk);
    ref_tick <= 1'b1;
    settle(16);
    chk(tx_width, 6 + 9);
    $display("test pulse widths done");
    apb(1'b1, fast_ir_line_pkg::LINE_CODING_ADDR, 32'h40);
    settle(1);
    chk(samp_en, 1'b1);
    for (int n = 5; n < 11; n++) begin
      rx_pulse(n);
      chk({sg, db}, (n == 7 || n == 8) ? 2'b10 : 2'b01);
    end
    apb(1'b1, fast_ir_line_pkg::LINE_CODING_ADDR, 32'h0);
    rx_pulse(4'h8);
    chk({sg, db}, 2'b00);
    $display("test receive classify done");
    apb(1'b1, fast_ir_line_pkg::LINE_CODING_ADDR, 32'h1);
    settle(2);
    chk(tx_line, 1'b1);
    @(posedge clk);
    tps <= 1'b1;
    tpd <= 1'b0;
    @(posedge clk);
    tps <= 1'b0;
    settle(1);
    chk(tx_line, 1'b0);
    $display("test line invert done");
    final_report;
  end
endmodule
